// ===== common/ddr4_ctl_pkg.sv
/*
 * Constants, types and register map for the control-pin logic of a DDR4
 * memory device. Assumes one 200 MHz clock standing in for CK_t/CK_c.
 */
// Functional notes
// - CKE high runs internal clocks, buffers, drivers; low stops them. The code keeps them off during the self refresh exit delay.
// - CKE low enters precharge or active power-down, or self refresh.
// - Self refresh exit follows CKE; delay counts from first high edge.
// - Power-down keeps only clock, ODT, reset and CKE input buffers on.
// - Self refresh keeps only CKE and reset input buffers enabled.
// - Every command is ignored on an edge where chip select is high.
// - Command code is chip select, activate and three command inputs.
// - Write data beats sampled with mask low are discarded.
// - Data mask is sampled on both edges of the data strobe.
// - In x16 upper mask covers upper byte, lower mask lower byte.
// - Mask, bus inversion and termination strobe act only when enabled.
// - ODT high terminates data, strobe, mask; x8 adds TDQS_c if on.
// - In x16 termination covers data, both strobe pairs, both masks.
// - When termination is disabled the ODT input is ignored entirely.
// - Parity covers command, address, bank, group and stack id inputs.
// - Parity excludes chip select, CKE and ODT.
// - Unused address inputs count as zero in the parity computation.
// - Parity is checked only for edges with chip select low.
// - Reset input low holds the device reset; controller keeps it high.
// - TEN high enters test mode; controller keeps it low in normal use. The code ignores TEN when stacked mode is set.
// - Activate low: command pins are row bits; high: they are commands.
// - A detected parity error is signalled on the alert output.
package ddr4_ctl_pkg;
	localparam int CLK_MHZ = 200;
	localparam int TXS_NS = 180;
	localparam int TXS_CYCLES = (TXS_NS * CLK_MHZ + 999) / 1000;
	localparam int ALERT_CYCLES = 6;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_AMASK = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_LASTCMD = 8'h0C;
	localparam int CTRL_DM_EN = 0;
	localparam int CTRL_DBI_EN = 1;
	localparam int CTRL_TDQS_EN = 2;
	localparam int CTRL_RTT_EN = 3;
	localparam int CTRL_PAR_EN = 4;
	localparam int CTRL_X16 = 5;
	localparam int CTRL_STACKED = 6;
	localparam logic [6:0] CTRL_RESET = 7'h00;
	localparam logic [17:0] AMASK_RESET = 18'h1_FFFF;
	localparam int STAT_PERR = 4;
	localparam int STAT_ERRCNT = 8;
	typedef enum {PWR_ACTIVE, PWR_PD_PRE, PWR_PD_ACT, PWR_SELF_REF,
		PWR_SR_EXIT} pwr_state_type;
	typedef enum logic [3:0] {CMD_DES, CMD_ACT, CMD_MRS, CMD_REF, CMD_PRE,
		CMD_RFU, CMD_WR, CMD_RD, CMD_ZQC, CMD_NOP} cmd_type;
	typedef struct packed {
		logic act_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [17:0] addr;
		logic [1:0] ba;
		logic [1:0] bg;
		logic [2:0] cid;
		logic par;
	} ca_pins_type;
	typedef struct packed {
		logic cmd_addr;
		logic odt;
		logic data;
	} ibuf_en_type;
	typedef struct packed {
		logic dq_lo;
		logic dq_hi;
		logic dqs_lo;
		logic dqs_hi;
		logic dm_lo;
		logic dm_hi;
		logic tdqs_c;
	} term_en_type;
endpackage

// ===== core/ddr4_ctl_pins.sv
/*
 * Control-pin logic of a DDR4 device: power state, command decode, parity
 * check, write data masking, termination enables and a Wishbone register
 * port. Assumes every pin input is asynchronous to clk_i and the bank
 * state comes from array logic on clk_i.
 */
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
module ddr4_ctl_pins #(
	parameter int TXS_CNT = ddr4_ctl_pkg::TXS_CYCLES,
	parameter int ALERT_CNT = ddr4_ctl_pkg::ALERT_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic reset_n_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic odt_i,
	input wire logic ten_i,
	input wire ddr4_ctl_pkg::ca_pins_type ca_i,
	input wire logic dqs_i,
	input wire logic [1:0] dm_n_i,
	input wire logic [15:0] dq_i,
	input wire logic wr_window_i,
	input wire logic bank_open_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic clk_run_o,
	output ddr4_ctl_pkg::ibuf_en_type ibuf_en_o,
	output ddr4_ctl_pkg::term_en_type term_en_o,
	output logic cmd_valid_o,
	output ddr4_ctl_pkg::cmd_type cmd_o,
	output logic [17:0] row_addr_o,
	output logic alert_n_o,
	output logic test_mode_o,
	output logic sr_exit_done_o,
	output logic beat_valid_o,
	output logic [15:0] beat_data_o,
	output logic [1:0] beat_byte_en_o
);
	import ddr4_ctl_pkg::*;

	// Elaboration checks on the count parameters.
	if (TXS_CNT < 1 || TXS_CNT > 65535) begin : g_bad_txs
		$error("Unsupported exit delay count.");
	end
	if (ALERT_CNT < 1 || ALERT_CNT > 255) begin : g_bad_alert
		$error("Unsupported alert length.");
	end

	function automatic logic [31:0] merge_sel(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Two-flop synchronisers for every pin input.
	localparam int SW = 5 + $bits(ca_pins_type) + 3 + 16;
	logic [SW-1:0] s1_q, s1_d, s2_q, s2_d;
	always_comb begin
		s1_d = {reset_n_i, cke_i, cs_n_i, odt_i, ten_i, ca_i, dqs_i, dm_n_i,
			dq_i};
		s2_d = s1_q;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
		end
	end
	logic rstn_s, cke_s, csn_s, odt_s, ten_s, dqs_s;
	ca_pins_type ca_s;
	logic [1:0] dmn_s;
	logic [15:0] dq_s;
	assign {rstn_s, cke_s, csn_s, odt_s, ten_s, ca_s, dqs_s, dmn_s, dq_s} =
		s2_q;

	// Core state.
	pwr_state_type pwr_q, pwr_d;
	logic [15:0] xs_q, xs_d;
	logic [7:0] alert_q, alert_d;
	logic alert_n_q, alert_n_d;
	logic [6:0] ctrl_q, ctrl_d;
	logic [17:0] amask_q, amask_d;
	logic perr_q, perr_d;
	logic [7:0] errcnt_q, errcnt_d;
	logic dqs_prev_q, dqs_prev_d;
	logic clk_run_q, clk_run_d;
	ibuf_en_type ibuf_q, ibuf_d;
	term_en_type term_q, term_d;
	logic cmd_valid_q, cmd_valid_d;
	cmd_type cmd_q, cmd_d;
	logic [17:0] row_q, row_d;
	logic test_q, test_d;
	logic xs_done_q, xs_done_d;
	logic bv_q, bv_d;
	logic [15:0] bdat_q, bdat_d;
	logic [1:0] ben_q, ben_d;
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;

	logic core_rst, wb_req, wb_wr, par_fail, dqs_edge, x16, stacked, sr_cmd;
	logic [17:0] amask_eff;
	logic [1:0] bg_eff;
	logic [2:0] cid_eff;
	logic [31:0] st_word;
	cmd_type dec;

	always_comb begin
		core_rst = rst_i || !rstn_s;
		x16 = ctrl_q[CTRL_X16];
		stacked = ctrl_q[CTRL_STACKED];
		wb_req = wb_cyc_i && wb_stb_i && !ack_q;
		wb_wr = wb_req && wb_we_i;
		// Command decode with chip select as part of the code.
		if (csn_s) begin
			dec = CMD_DES;
		end else if (!ca_s.act_n) begin
			dec = CMD_ACT;
		end else begin
			case ({ca_s.ras_n, ca_s.cas_n, ca_s.we_n})
			3'b000: dec = CMD_MRS;
			3'b001: dec = CMD_REF;
			3'b010: dec = CMD_PRE;
			3'b011: dec = CMD_RFU;
			3'b100: dec = CMD_WR;
			3'b101: dec = CMD_RD;
			3'b110: dec = CMD_ZQC;
			default: dec = CMD_NOP;
			endcase
		end
		sr_cmd = (dec == CMD_REF) && !cke_s && ibuf_q.cmd_addr &&
			!test_q;
		// Unused inputs count as zero; command inputs are always covered.
		amask_eff = amask_q & 18'h2_3FFF;
		bg_eff = x16 ? {1'b0, ca_s.bg[0]} : ca_s.bg;
		cid_eff = stacked ? ca_s.cid : 3'h0;
		par_fail = ^{ca_s.act_n, ca_s.ras_n, ca_s.cas_n, ca_s.we_n,
			ca_s.addr & amask_eff,
			ca_s.ba, bg_eff, cid_eff, ca_s.par};
		dqs_edge = dqs_s != dqs_prev_q;
		st_word = '0;
		st_word[2:0] = 3'(pwr_q);
		st_word[3] = test_q;
		st_word[STAT_PERR] = perr_q;
		st_word[STAT_ERRCNT +: 8] = errcnt_q;
	end

	always_comb begin
		pwr_d = pwr_q;
		xs_d = xs_q;
		xs_done_d = 1'b0;
		alert_d = (alert_q != 8'h00) ? alert_q - 8'h01 : alert_q;
		ctrl_d = ctrl_q;
		amask_d = amask_q;
		perr_d = perr_q;
		errcnt_d = errcnt_q;
		dqs_prev_d = dqs_s;
		cmd_valid_d = 1'b0;
		cmd_d = cmd_q;
		row_d = row_q;
		test_d = ten_s && !stacked;
		bv_d = 1'b0;
		bdat_d = bdat_q;
		ben_d = 2'b00;
		ack_d = wb_req;
		rdat_d = 32'h0000_0000;
		case (pwr_q)
		PWR_ACTIVE: begin
			if (sr_cmd && !bank_open_i) begin
				pwr_d = PWR_SELF_REF;
			end else if (!cke_s) begin
				pwr_d = bank_open_i ? PWR_PD_ACT : PWR_PD_PRE;
			end
		end
		PWR_PD_PRE, PWR_PD_ACT: begin
			if (cke_s) begin
				pwr_d = PWR_ACTIVE;
			end
		end
		PWR_SELF_REF: begin
			if (cke_s) begin
				pwr_d = PWR_SR_EXIT;
				xs_d = 16'(TXS_CNT - 1);
			end
		end
		PWR_SR_EXIT: begin
			if (!cke_s) begin
				pwr_d = PWR_SELF_REF;
			end else if (xs_q == 16'h0000) begin
				pwr_d = PWR_ACTIVE;
				xs_done_d = 1'b1;
			end else begin
				xs_d = xs_q - 16'h0001;
			end
		end
		default: pwr_d = PWR_ACTIVE;
		endcase
		clk_run_d = cke_s && (pwr_d == PWR_ACTIVE);
		ibuf_d.cmd_addr = clk_run_d;
		ibuf_d.odt = pwr_d != PWR_SELF_REF && pwr_d != PWR_SR_EXIT;
		ibuf_d.data = clk_run_d;
		// Commands are taken only with buffers up and test mode off.
		if (pwr_q == PWR_ACTIVE && ibuf_q.cmd_addr && !test_q && !csn_s) begin
			cmd_valid_d = 1'b1;
			cmd_d = dec;
			if (dec == CMD_ACT) begin
				row_d = ca_s.addr;
			end
			if (ctrl_q[CTRL_PAR_EN] && par_fail) begin
				alert_d = 8'(ALERT_CNT);
				errcnt_d = errcnt_q + 8'h01;
			end
		end
		// Termination enables, gated by the ODT buffer and mode bits.
		term_d = '0;
		if (ctrl_q[CTRL_RTT_EN] && ibuf_d.odt && odt_s) begin
			term_d.dq_lo = 1'b1;
			term_d.dqs_lo = 1'b1;
			term_d.dm_lo = 1'b1;
			term_d.dq_hi = x16;
			term_d.dqs_hi = x16;
			term_d.dm_hi = x16;
			term_d.tdqs_c = !x16 && ctrl_q[CTRL_TDQS_EN];
		end
		// Write beats on each strobe edge, masked bytes dropped.
		if (ibuf_q.data && wr_window_i && dqs_edge) begin
			bv_d = 1'b1;
			bdat_d = dq_s;
			ben_d = x16 ? 2'b11 : 2'b01;
			if (ctrl_q[CTRL_DM_EN] && !ctrl_q[CTRL_TDQS_EN]) begin
				ben_d = ben_d & dmn_s;
			end
		end
		// Register port; a new error wins over a write-one clear.
		if (wb_wr && wb_adr_i == REG_CTRL) begin
			ctrl_d = 7'(merge_sel({25'h0, ctrl_q}, wb_dat_i, wb_sel_i));
		end
		if (wb_wr && wb_adr_i == REG_AMASK) begin
			amask_d = 18'(merge_sel({14'h0, amask_q}, wb_dat_i, wb_sel_i));
		end
		if (wb_wr && wb_adr_i == REG_STATUS && wb_sel_i[0] &&
			wb_dat_i[STAT_PERR]) begin
			perr_d = 1'b0;
		end
		if (errcnt_d != errcnt_q) begin
			perr_d = 1'b1;
		end
		// The alert pin leaves a flop of its own, low while the count runs.
		alert_n_d = alert_d == 8'h00;
		if (wb_req && !wb_we_i) begin
			case (wb_adr_i)
			REG_CTRL: rdat_d = {25'h0, ctrl_q};
			REG_AMASK: rdat_d = {14'h0, amask_q};
			REG_STATUS: rdat_d = st_word;
			REG_LASTCMD: rdat_d = {10'h0, cmd_q, row_q};
			default: rdat_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			pwr_q <= PWR_ACTIVE;
			xs_q <= '0;
			xs_done_q <= 1'b0;
			alert_q <= '0;
			alert_n_q <= 1'b1;
			ctrl_q <= CTRL_RESET;
			amask_q <= AMASK_RESET;
			perr_q <= 1'b0;
			errcnt_q <= '0;
			dqs_prev_q <= 1'b0;
			clk_run_q <= 1'b0;
			ibuf_q <= '0;
			term_q <= '0;
			cmd_valid_q <= 1'b0;
			cmd_q <= CMD_DES;
			row_q <= '0;
			test_q <= 1'b0;
			bv_q <= 1'b0;
			bdat_q <= '0;
			ben_q <= '0;
			ack_q <= 1'b0;
			rdat_q <= '0;
		end else begin
			pwr_q <= pwr_d;
			xs_q <= xs_d;
			xs_done_q <= xs_done_d;
			alert_q <= alert_d;
			alert_n_q <= alert_n_d;
			ctrl_q <= ctrl_d;
			amask_q <= amask_d;
			perr_q <= perr_d;
			errcnt_q <= errcnt_d;
			dqs_prev_q <= dqs_prev_d;
			clk_run_q <= clk_run_d;
			ibuf_q <= ibuf_d;
			term_q <= term_d;
			cmd_valid_q <= cmd_valid_d;
			cmd_q <= cmd_d;
			row_q <= row_d;
			test_q <= test_d;
			bv_q <= bv_d;
			bdat_q <= bdat_d;
			ben_q <= ben_d;
			ack_q <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	assign wb_dat_o = rdat_q;
	assign wb_ack_o = ack_q;
	assign clk_run_o = clk_run_q;
	assign ibuf_en_o = ibuf_q;
	assign term_en_o = term_q;
	assign cmd_valid_o = cmd_valid_q;
	assign cmd_o = cmd_q;
	assign row_addr_o = row_q;
	assign alert_n_o = alert_n_q;
	assign test_mode_o = test_q;
	assign sr_exit_done_o = xs_done_q;
	assign beat_valid_o = bv_q;
	assign beat_data_o = bdat_q;
	assign beat_byte_en_o = ben_q;
endmodule

// ===== dv/ddr4_control_pin_logic_bench.sv
/* Self-checking bench for the DDR4 control-pin block.
 * Assumes the host model drives every device pin. */
`timescale 1ns/100ps
module ddr4_control_pin_logic_bench;
	import ddr4_ctl_pkg::*;
	typedef struct packed {logic [3:0] c; cmd_type e;} row_type;
	logic clk_i, rst_i, reset_n_i, cke_i, cs_n_i, odt_i, ten_i, dqs_i;
	logic wr_window_i, bank_open_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
	logic clk_run_o, cmd_valid_o, alert_n_o, test_mode_o, sr_exit_done_o;
	logic beat_valid_o;
	logic pa = 1'b1;
	logic [1:0] dm_n_i, beat_byte_en_o, lb;
	logic [15:0] dq_i, beat_data_o;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [3:0] wb_sel_i;
	logic [17:0] row_addr_o;
	ca_pins_type ca_i;
	ibuf_en_type ibuf_en_o;
	term_en_type term_en_o;
	cmd_type cmd_o, lc;
	int num_errors = 0, n_checks = 0, ncmd = 0, nal = 0, nsr = 0, nb = 0, m;
	row_type rows [9] = '{'{4'h0, CMD_ACT}, '{4'h8, CMD_MRS},
		'{4'h9, CMD_REF}, '{4'hA, CMD_PRE}, '{4'hB, CMD_RFU},
		'{4'hC, CMD_WR}, '{4'hD, CMD_RD}, '{4'hE, CMD_ZQC}, '{4'hF, CMD_NOP}};
	logic [11:0] bt [4] = '{12'h21A, 12'h215, 12'h203, 12'h010};
	logic [14:0] tm [3] = '{15'h147E, 15'h0655, 15'h1000};
	ddr4_ctl_pins #(.TXS_CNT(4)) ddr4_ctl_pins_inst (.clk_i, .rst_i,
		.reset_n_i, .cke_i, .cs_n_i, .odt_i, .ten_i, .ca_i, .dqs_i, .dm_n_i,
		.dq_i, .wr_window_i, .bank_open_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
		.wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .clk_run_o,
		.ibuf_en_o, .term_en_o, .cmd_valid_o, .cmd_o, .row_addr_o,
		.alert_n_o, .test_mode_o, .sr_exit_done_o, .beat_valid_o,
		.beat_data_o, .beat_byte_en_o);
	host host_inst (.clk_i, .reset_n_o(reset_n_i), .cke_o(cke_i),
		.cs_n_o(cs_n_i), .odt_o(odt_i), .ten_o(ten_i), .ca_o(ca_i),
		.dqs_o(dqs_i), .dm_n_o(dm_n_i), .dq_o(dq_i));
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (cmd_valid_o === 1'b1) begin
			ncmd++;
			lc = cmd_o;
		end
		if (beat_valid_o === 1'b1) begin
			nb++;
			lb = beat_byte_en_o;
		end
		if (sr_exit_done_o === 1'b1) nsr++;
		if (alert_n_o === 1'b0 && pa === 1'b1) nal++;
		pa = alert_n_o;
	end
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
		wb_adr_i <= a;
		wb_dat_i <= d;
		for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(posedge clk_i);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		if (i == 20) begin
			num_errors++;
			wrap_up();
		end
	endtask
	task automatic st(input logic [2:0] e);
		wb(1'b0, 8'h08, 32'h0000_0000);
		chk("state", e, q[2:0]);
	endtask
	task automatic try(input logic [3:0] c, input logic [17:0] a,
		input logic [2:0] bsk, input int dc, input int da);
		int c0, a0;
		c0 = ncmd;
		a0 = nal;
		host_inst.cmd(c, a, bsk[2], bsk[1], bsk[0]);
		cyc(6);
		chk("commands", c0 + dc, ncmd);
		chk("alerts", a0 + da, nal);
	endtask
	initial begin
		rst_i = 1'b1;
		{wr_window_i, bank_open_i, wb_we_i, wb_cyc_i, wb_stb_i} = '0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0000_0000;
		wb_sel_i = 4'hF;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		cyc(3);
		chk("reset alert", 1, alert_n_o);
		chk("reset code", CMD_DES, cmd_o);
		foreach (rows[i]) begin
			try(rows[i].c, 18'h0_1234, 3'b001, 1, 0);
			chk("code", rows[i].e, lc);
		end
		chk("row", 18'h0_1234, row_addr_o);
		try(4'hD, 18'h0_0000, 3'b011, 0, 0);
		wb(1'b1, 8'h00, 32'h0000_0010);
		try(4'hD, 18'h0_0005, 3'b101, 1, 1);
		try(4'hD, 18'h0_0005, 3'b111, 0, 0);
		wb(1'b1, 8'h04, 32'h0000_03FF);
		host_inst.amask = 18'h0_03FF;
		try(4'hD, 18'h0_0400, 3'b001, 1, 0);
		bank_open_i <= 1'b1;
		host_inst.pins(1'b1, 1'b0, 1'b0, 1'b0);
		cyc(8);
		st(3'h2);
		chk("clock", 0, clk_run_o);
		chk("buffers", 3'h2, ibuf_en_o);
		try(4'hA, 18'h0_0000, 3'b000, 0, 0);
		host_inst.pins(1'b1, 1'b0, 1'b0, 1'b1);
		bank_open_i <= 1'b0;
		cyc(8);
		st(3'h0);
		host_inst.pins(1'b1, 1'b0, 1'b0, 1'b0);
		cyc(8);
		st(3'h1);
		host_inst.pins(1'b1, 1'b0, 1'b0, 1'b1);
		cyc(8);
		host_inst.cmd(4'h9, 18'h0_0000, 1'b0, 1'b0, 1'b0);
		cyc(8);
		st(3'h3);
		chk("sr buffers", 3'h0, ibuf_en_o);
		m = nsr;
		host_inst.pins(1'b1, 1'b0, 1'b0, 1'b1);
		cyc(12);
		chk("exit", m + 1, nsr);
		st(3'h0);
		wr_window_i <= 1'b1;
		foreach (bt[i]) begin
			wb(1'b1, 8'h00, {24'h00_0000, bt[i][11:4]});
			host_inst.beat(bt[i][3:2]);
			cyc(6);
			chk("beats", i + 1, nb);
			chk("data", {16'h0000, {16{~i[0]}}}, beat_data_o);
			chk("bytes", bt[i][1:0], lb);
		end
		host_inst.pins(1'b1, 1'b0, 1'b1, 1'b1);
		foreach (tm[i]) begin
			wb(1'b1, 8'h00, {24'h00_0000, tm[i][14:7]});
			cyc(4);
			chk("term", tm[i][6:0], term_en_o);
		end
		host_inst.pins(1'b1, 1'b1, 1'b0, 1'b1);
		cyc(6);
		chk("test", 1, test_mode_o);
		try(4'hD, 18'h0_0000, 3'b001, 0, 0);
		host_inst.pins(1'b0, 1'b0, 1'b0, 1'b1);
		cyc(6);
		chk("reset cmd", CMD_DES, cmd_o);
		chk("reset clock", 0, clk_run_o);
		host_inst.pins(1'b1, 1'b0, 1'b0, 1'b1);
		cyc(4);
		wb(1'b0, 8'h10, 32'h0000_0000);
		chk("unmapped", 0, q);
		wrap_up();
	end
endmodule

// ===== dv/ddr4_ctl_pins_props.sv
/* Assertions on the ports of ddr4_ctl_pins.
 * Assumes one clock clk_i with synchronous reset rst_i. */
`timescale 1ns/100ps
module ddr4_ctl_pins_props #(
	parameter int TXS_CNT = 4,
	parameter int ALERT_CNT = 6
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic reset_n_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic ten_i,
	input wire ddr4_ctl_pkg::ca_pins_type ca_i,
	input wire logic clk_run_o,
	input wire ddr4_ctl_pkg::ibuf_en_type ibuf_en_o,
	input wire logic cmd_valid_o,
	input wire ddr4_ctl_pkg::cmd_type cmd_o,
	input wire logic alert_n_o,
	input wire logic test_mode_o,
	input wire logic sr_exit_done_o
);
	import ddr4_ctl_pkg::*;
	logic [7:0] hi_q, hi_d, lo_q, lo_d;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	always_comb begin
		hi_d = cke_i ? hi_q + {7'h00, hi_q != 8'hFF} : 8'h00;
		lo_d = alert_n_o ? 8'h00 : lo_q + 8'h01;
	end
	always_ff @(posedge clk_i) begin
		hi_q <= rst_i ? 8'h00 : hi_d;
		lo_q <= rst_i ? 8'h00 : lo_d;
	end
	property p_cke;
		cke_i == 1'b0 [*5] |-> !clk_run_o;
	endproperty
	a_cke: assert property (p_cke) else $error("clock runs");
	property p_pd;
		cke_i == 1'b0 [*6] |-> !ibuf_en_o.cmd_addr;
	endproperty
	a_pd: assert property (p_pd) else $error("cmd buffer on");
	property p_sr;
		!ibuf_en_o.odt |-> !ibuf_en_o.cmd_addr && !ibuf_en_o.data;
	endproperty
	a_sr: assert property (p_sr) else $error("buffer on");
	property p_cs;
		cmd_valid_o |-> !$past(cs_n_i, 3) || !$past(cs_n_i, 4);
	endproperty
	a_cs: assert property (p_cs) else $error("masked cmd");
	property p_act;
		cmd_valid_o && cmd_o == CMD_ACT |->
			!$past(ca_i.act_n, 3) || !$past(ca_i.act_n, 4);
	endproperty
	a_act: assert property (p_act) else $error("bad activate");
	property p_alert;
		$rose(alert_n_o) |-> lo_q == ALERT_CNT;
	endproperty
	a_alert: assert property (p_alert) else $error("alert length");
	property p_ten;
		ten_i == 1'b0 [*5] |-> !test_mode_o;
	endproperty
	a_ten: assert property (p_ten) else $error("test mode");
	property p_sre;
		sr_exit_done_o |-> hi_q >= TXS_CNT && hi_q <= TXS_CNT + 4;
	endproperty
	a_sre: assert property (p_sre) else $error("exit delay");
	property p_rst;
		reset_n_i == 1'b0 [*5] |-> alert_n_o && !clk_run_o;
	endproperty
	a_rst: assert property (p_rst) else $error("not reset");
endmodule
bind ddr4_ctl_pins ddr4_ctl_pins_props #(.TXS_CNT(TXS_CNT),
	.ALERT_CNT(ALERT_CNT)) props_inst (.clk_i, .rst_i, .reset_n_i, .cke_i,
	.cs_n_i, .ten_i, .ca_i, .clk_run_o, .ibuf_en_o, .cmd_valid_o, .cmd_o,
	.alert_n_o, .test_mode_o, .sr_exit_done_o);

// ===== dv/host.sv
/* Memory controller model driving the DDR4 control pins.
 * Assumes the device samples on the rising edge of clk_i. */
`timescale 1ns/100ps
module host (
	input wire logic clk_i,
	output logic reset_n_o,
	output logic cke_o,
	output logic cs_n_o,
	output logic odt_o,
	output logic ten_o,
	output ddr4_ctl_pkg::ca_pins_type ca_o,
	output logic dqs_o,
	output logic [1:0] dm_n_o,
	output logic [15:0] dq_o
);
	import ddr4_ctl_pkg::*;
	logic [17:0] amask = 18'h1_FFFF;
	initial begin
		{reset_n_o, cke_o, cs_n_o, odt_o, ten_o} = 5'h1C;
		ca_o = '0;
		{dqs_o, dm_n_o, dq_o} = '0;
	end
	task automatic pins(input logic r, input logic t, input logic o,
		input logic k);
		@(posedge clk_i);
		reset_n_o <= r;
		ten_o <= t;
		odt_o <= o;
		cke_o <= k;
	endtask
	task automatic cmd(input logic [3:0] c, input logic [17:0] a,
		input logic b, input logic s, input logic k);
		ca_pins_type v;
		v = '0;
		{v.act_n, v.ras_n, v.cas_n, v.we_n} = c;
		v.addr = a;
		v.par = ^{c, a & amask & 18'h2_3FFF} ^ b;
		@(posedge clk_i);
		ca_o <= v;
		cs_n_o <= s;
		cke_o <= k;
		@(posedge clk_i);
		cs_n_o <= 1'b1;
		ca_o <= ~v;
	endtask
	task automatic beat(input logic [1:0] m);
		@(posedge clk_i);
		dm_n_o <= m;
		dq_o <= ~dq_o;
		dqs_o <= ~dqs_o;
	endtask
endmodule
